// [verilog/asc_pkg.sv]
// Package for the scan trigger and interrupt enable block.
// Assumes AXI4-Lite with 32-bit data and byte addresses.
package asc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W  = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_LOWLIM = 8'h0c;
  localparam logic [7:0] OFS_HIGLIM = 8'h10;
  localparam logic [7:0] OFS_ZCCFG  = 8'h14;
  localparam logic [7:0] OFS_OFFSET = 8'h18;

  // Control register fields
  localparam int unsigned BIT_HALT  = 14;
  localparam int unsigned BIT_START = 13;
  localparam int unsigned BIT_SYNC  = 12;
  localparam int unsigned BIT_EOSIE = 11;
  localparam int unsigned BIT_ZERO_CROSS_IRQ_ENABLE  = 10;
  localparam int unsigned BIT_LLIE  = 9;
  localparam int unsigned BIT_HLIE  = 8;
  localparam logic [15:0] CTRL_RESET    = 16'h5005;
  localparam logic [15:0] CTRL_WR_MASK  = 16'h5f07;
  localparam logic [15:0] CTRL_RD_MASK  = 16'h5f07;

  // Status and mask fields
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_ZC   = 1;
  localparam int unsigned ST_LOW  = 2;
  localparam int unsigned ST_HIGH = 3;
  localparam int unsigned ST_BUSY = 8;
  localparam int unsigned ST_ARMD = 9;
  localparam int unsigned NUM_EV  = 4;

  // Scan modes, low three bits of control
  localparam logic [2:0] MODE_ONCE_SEQ = 3'h0;
  localparam logic [2:0] MODE_ONCE_PAR = 3'h1;
  localparam logic [2:0] MODE_LOOP_SEQ = 3'h2;
  localparam logic [2:0] MODE_LOOP_PAR = 3'h3;

  // Zero crossing configurations
  localparam logic [1:0] ZC_OFF    = 2'h0;
  localparam logic [1:0] ZC_POSNEG = 2'h1;
  localparam logic [1:0] ZC_NEGPOS = 2'h2;
  localparam logic [1:0] ZC_ANY    = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : asc_pkg

// [verilog/asc_scan_ctrl.sv]
// Scan start, trigger arming and scan event interrupts of a dual ADC.
// Assumes one clock, synchronous inputs and an AXI4-Lite master.
//
// Functional notes
// - With sync enable set, a trigger rising edge starts a scan too.
// - With sync enable clear, only a software start command starts scans.
// - Trigger edges arriving during a running scan are ignored.
// - Once modes honour one trigger edge until sync enable is rewritten.
// - Writing sync enable to one re-arms at any time, even mid-scan.
// - End-of-scan enable lets a finished scan raise its interrupt.
// - Loop modes raise end-of-scan after every iteration.
// - Zero-cross enable flags sign changes per zero-cross configuration.
// - Low-limit enable flags results below the low limit.
// - High-limit enable flags results above the high limit.
// - Limits compare the raw result before offset subtraction.
// - Start command is write-only; repeats ignored until scan ends.
// - Halt stops the scan and blocks triggers and start commands.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
module asc_scan_ctrl
  import asc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              syncTrigger,
  input  wire logic              iterDone,
  input  wire logic              resultValid,
  input  wire logic [RES_W-1:0]  resultData,
  output logic                   scanStart,
  output logic                   scanBusy,
  output logic                   scanHaltOut,
  output logic                   corrValid,
  output logic [RES_W-1:0]       corrData,
  output logic                   irq
);

  function automatic logic [15:0] mergeLow(input logic [15:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    mergeLow = old;
    if (strb[0]) mergeLow[7:0] = data[7:0];
    if (strb[1]) mergeLow[15:8] = data[15:8];
  endfunction : mergeLow

  function automatic logic isOnce(input logic [2:0] mode);
    isOnce = (mode == MODE_ONCE_SEQ) || (mode == MODE_ONCE_PAR);
  endfunction : isOnce

  function automatic logic isLoop(input logic [2:0] mode);
    isLoop = (mode == MODE_LOOP_SEQ) || (mode == MODE_LOOP_PAR);
  endfunction : isLoop

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK) ||
               (a == OFS_LOWLIM) || (a == OFS_HIGLIM) ||
               (a == OFS_ZCCFG) || (a == OFS_OFFSET);
  endfunction : isMapped

  logic [15:0]       ctrl;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] mask;
  logic [15:0]       lowLimit;
  logic [15:0]       highLimit;
  logic [1:0]        zcCfg;
  logic [15:0]       offset;
  logic              trigArmed;
  logic              trigPrev;
  logic              prevSign;
  logic              signSeen;
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0]       wData;
  logic [3:0]        wStrb;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic        doWrite;
  logic        wrCtrl;
  logic [15:0] next_ctrl;

  assign doWrite   = awHeld && wHeld && !s_axi_bvalid;
  assign wrCtrl    = doWrite && (awAddr == OFS_CTRL);
  assign next_ctrl = mergeLow(ctrl, wData, wStrb);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      awHeld        <= 1'b0;
      awAddr        <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld        <= 1'b1;
      awAddr        <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end else if (!awHeld) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wHeld        <= 1'b0;
      wData        <= '0;
      wStrb        <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld        <= 1'b1;
      wData        <= s_axi_wdata;
      wStrb        <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end else if (!wHeld) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [15:0] maskMerged;
  logic [15:0] zcMerged;

  assign maskMerged = mergeLow({12'h000, mask}, wData, wStrb);
  assign zcMerged   = mergeLow({14'h0000, zcCfg}, wData, wStrb);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wrCtrl) begin
      // Start command bit is never stored
      ctrl <= next_ctrl & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask      <= '0;
      lowLimit  <= '0;
      highLimit <= '0;
      zcCfg     <= ZC_OFF;
      offset    <= '0;
    end else if (doWrite) begin
      unique case (awAddr)
        OFS_MASK:   mask <= maskMerged[NUM_EV-1:0];
        OFS_LOWLIM: lowLimit <= mergeLow(lowLimit, wData, wStrb);
        OFS_HIGLIM: highLimit <= mergeLow(highLimit, wData, wStrb);
        OFS_ZCCFG:  zcCfg <= zcMerged[1:0];
        OFS_OFFSET: offset <= mergeLow(offset, wData, wStrb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan start and trigger arming

  logic syncEnable;
  logic scanHalt;
  logic trigEdge;
  logic trigStart;
  logic swStart;
  logic startAccept;
  logic rearm;

  assign syncEnable = ctrl[BIT_SYNC];
  assign scanHalt   = ctrl[BIT_HALT];
  assign trigEdge   = syncTrigger && !trigPrev;
  // Edges only count while enabled, armed, idle and not halted
  assign trigStart  = syncEnable && trigArmed && trigEdge &&
                      !scanBusy && !scanHalt;
  assign swStart    = wrCtrl && wStrb[1] && wData[BIT_START] &&
                      !scanBusy && !scanHalt &&
                      !next_ctrl[BIT_HALT];
  assign startAccept = trigStart || swStart;
  assign rearm      = wrCtrl && wStrb[1] && wData[BIT_SYNC];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= syncTrigger;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trigArmed <= 1'b1;
    end else if (rearm) begin
      trigArmed <= 1'b1;
    end else if (trigStart && isOnce(ctrl[2:0])) begin
      trigArmed <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scanStart   <= 1'b0;
      scanBusy    <= 1'b0;
      scanHaltOut <= 1'b1;
    end else begin
      scanStart   <= startAccept;
      scanHaltOut <= scanHalt;
      if (scanHalt) begin
        scanBusy <= 1'b0;
      end else if (startAccept) begin
        scanBusy <= 1'b1;
      end else if (iterDone && !isLoop(ctrl[2:0])) begin
        scanBusy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result checks and sticky status

  logic              zcEvent;
  logic [NUM_EV-1:0] events;
  logic [NUM_EV-1:0] clearBits;

  always_comb begin
    zcEvent = 1'b0;
    if (resultValid && signSeen) begin
      unique case (zcCfg)
        ZC_OFF:    zcEvent = 1'b0;
        ZC_POSNEG: zcEvent = !prevSign && resultData[RES_W-1];
        ZC_NEGPOS: zcEvent = prevSign && !resultData[RES_W-1];
        ZC_ANY:    zcEvent = prevSign != resultData[RES_W-1];
      endcase
    end
  end

  // Limits see the raw result, not the offset-corrected one
  assign events[ST_DONE] = iterDone && scanBusy && ctrl[BIT_EOSIE];
  assign events[ST_ZC]   = zcEvent && ctrl[BIT_ZERO_CROSS_IRQ_ENABLE];
  assign events[ST_LOW]  = resultValid && ctrl[BIT_LLIE] &&
                           (resultData < lowLimit);
  assign events[ST_HIGH] = resultValid && ctrl[BIT_HLIE] &&
                           (resultData > highLimit);
  assign clearBits = (doWrite && (awAddr == OFS_STATUS) && wStrb[0]) ?
                     wData[NUM_EV-1:0] : '0;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prevSign <= 1'b0;
      signSeen <= 1'b0;
    end else if (resultValid) begin
      prevSign <= resultData[RES_W-1];
      signSeen <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      // A new event wins over a clear in the same cycle
      status <= (status & ~clearBits) | events;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~clearBits) | events) & mask);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      corrValid <= 1'b0;
      corrData  <= '0;
    end else begin
      corrValid <= resultValid;
      if (resultValid) begin
        corrData <= resultData - offset;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  logic [31:0] rdMux;

  always_comb begin
    rdMux = '0;
    unique case (s_axi_araddr)
      OFS_CTRL:   rdMux[15:0] = ctrl & CTRL_RD_MASK;
      OFS_STATUS: begin
        rdMux[NUM_EV-1:0] = status;
        rdMux[ST_BUSY]    = scanBusy;
        rdMux[ST_ARMD]    = trigArmed;
      end
      OFS_MASK:   rdMux[NUM_EV-1:0] = mask;
      OFS_LOWLIM: rdMux[15:0] = lowLimit;
      OFS_HIGLIM: rdMux[15:0] = highLimit;
      OFS_ZCCFG:  rdMux[1:0] = zcCfg;
      OFS_OFFSET: rdMux[15:0] = offset;
      default:    rdMux = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_TRIG_START: assert property (
    trigStart |=> scanStart && scanBusy)
    else $error("accepted trigger edge did not start a scan");

  AST_NO_TRIG_DIS: assert property (
    !syncEnable && !swStart |=> !scanStart)
    else $error("scan started without command while sync disabled");

  AST_BUSY_IGNORE: assert property (
    scanBusy |=> !scanStart)
    else $error("scan started while one was running");

  AST_ONCE_DISARM: assert property (
    trigStart && isOnce(ctrl[2:0]) && !rearm |=> !trigArmed ##1
    (!trigArmed || $past(rearm)))
    else $error("once mode stayed armed after trigger");

  AST_REARM: assert property (
    rearm |=> trigArmed && syncEnable)
    else $error("sync enable write did not re-arm");

  AST_EOS_IRQ: assert property (
    iterDone && scanBusy && ctrl[BIT_EOSIE] |=> status[ST_DONE])
    else $error("end of scan not flagged");

  AST_EOS_OFF: assert property (
    !ctrl[BIT_EOSIE] && !status[ST_DONE] |=> !status[ST_DONE])
    else $error("end of scan flagged while disabled");

  AST_LOOP_ITER: assert property (
    iterDone && scanBusy && !scanHalt && isLoop(ctrl[2:0]) |=> scanBusy)
    else $error("loop scan ended at iteration");

  AST_ZC: assert property (
    zcEvent && ctrl[BIT_ZERO_CROSS_IRQ_ENABLE] |=> status[ST_ZC])
    else $error("zero crossing not flagged");

  AST_LOW: assert property (
    resultValid && ctrl[BIT_LLIE] && resultData < lowLimit
    |=> status[ST_LOW])
    else $error("low limit not flagged");

  AST_HIGH: assert property (
    resultValid && ctrl[BIT_HLIE] && resultData > highLimit
    |=> status[ST_HIGH])
    else $error("high limit not flagged");

  AST_OFFSET: assert property (
    resultValid |=> corrData == $past(resultData) - $past(offset))
    else $error("corrected result wrong");

  AST_HALT: assert property (
    scanHalt |=> !scanBusy && !scanStart)
    else $error("halt did not stop scanning");

  AST_IRQ: assert property (
    |(status & mask) && clearBits == '0 |-> ##[0:1] irq)
    else $error("unmasked status without interrupt");

  COV_TRIG: cover property (trigStart ##[1:20] iterDone);
  COV_SW: cover property (swStart ##1 scanBusy);
  COV_REARM: cover property (trigStart ##[1:30] rearm);
  COV_IRQ: cover property ($rose(irq));

endmodule : asc_scan_ctrl

// [tb/asc_far_end.sv]
// Far-side model: external trigger source and converter sequencer.
// Assumes the bench requests trigger pulses and sets the scan length.
`timescale 1ns/1ns
module asc_far_end (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       trigReq,
  input  wire logic [7:0] scanLen,
  input  wire logic       scanStart,
  input  wire logic       scanBusy,
  output logic            syncTrigger,
  output logic            iterDone
);
  logic [7:0] count;

  ////////////////////////////////////////
  // Trigger line follows the request, low between pulses
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      syncTrigger <= 1'b0;
    end else begin
      syncTrigger <= trigReq;
    end
  end

  // Each scan or loop iteration lasts scanLen+1 cycles
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count    <= 8'h00;
      iterDone <= 1'b0;
    end else begin
      iterDone <= 1'b0;
      if (scanStart) begin
        count <= scanLen;
      end else if (scanBusy && !iterDone) begin
        if (count <= 8'h01) begin
          iterDone <= 1'b1;
          count    <= scanLen;
        end else begin
          count <= count - 8'h01;
        end
      end
    end
  end
endmodule : asc_far_end

// [tb/asc_scan_ctrl_test.sv]
// Bench for the scan trigger and interrupt enable block.
// Assumes asc_far_end as trigger source and converter, AXI4-Lite access.
`timescale 1ns/1ns
module asc_scan_ctrl_test
  import asc_pkg::*;
  ;
  logic              core_clk      = 1'b0;
  logic              reset         = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr  = '0;
  logic              s_axi_awvalid = 1'b0;
  logic [DATA_W-1:0] s_axi_wdata   = '0;
  logic [3:0]        s_axi_wstrb   = 4'hf;
  logic              s_axi_wvalid  = 1'b0;
  logic              s_axi_bready  = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr  = '0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready  = 1'b0;
  logic              resultValid   = 1'b0;
  logic [RES_W-1:0]  resultData    = '0;
  logic              trigReq       = 1'b0;
  logic [7:0]        scanLen       = 8'h14;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, syncTrigger, iterDone;
  logic              scanStart, scanBusy, scanHaltOut, corrValid, irq;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [RES_W-1:0]  corrData;
  int                fails       = 0;
  int                comparisons = 0;
  int                nStart      = 0;
  int                cyc         = 0;
  logic [1:0]  zcTab [9] = '{ZC_OFF, ZC_ANY, ZC_ANY, ZC_NEGPOS, ZC_POSNEG,
                             ZC_POSNEG, ZC_NEGPOS, ZC_OFF, ZC_ANY};
  logic [15:0] dTab [9]  = '{16'h0200, 16'h0050, 16'h0900, 16'h8000,
                             16'h0010, 16'h8000, 16'h0200, 16'h0350, 16'h8000};
  logic [3:0]  eTab [9]  = '{4'h0, 4'h4, 4'h8, 4'h8, 4'h4, 4'ha, 4'h2, 4'h0,
                             4'ha};

  always #10 core_clk = ~core_clk;

  asc_scan_ctrl asc_scan_ctrl_inst (.core_clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .syncTrigger, .iterDone, .resultValid, .resultData,
    .scanStart, .scanBusy, .scanHaltOut, .corrValid, .corrData, .irq);

  asc_far_end asc_far_end_inst (.core_clk, .reset, .trigReq, .scanLen,
    .scanStart, .scanBusy, .syncTrigger, .iterDone);

  ////////////////////////////////////////
  always @(posedge core_clk) begin
    if (scanStart === 1'b1) nStart <= nStart + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Unmapped offsets answer with a slave error
  function automatic logic [31:0] respOf(input logic [7:0] a);
    return (a > OFS_OFFSET) ? {30'h0, RESP_SLVERR} : {30'h0, RESP_OKAY};
  endfunction : respOf

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0;
    bit w = 0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", respOf(a), {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", respOf(a), {30'h0, s_axi_rresp});
    chk("rdata", e, s_axi_rdata & m);
  endtask : rd

  task automatic trig();
    @(posedge core_clk);
    trigReq <= 1'b1;
    repeat (2) @(posedge core_clk);
    trigReq <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : trig

  task automatic waitIdle();
    do @(posedge core_clk); while (scanBusy !== 1'b0);
  endtask : waitIdle

  task automatic waitIrq(input logic v);
    int n = 0;
    while (irq !== v && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    chk("irq", {31'h0, v}, {31'h0, irq});
  endtask : waitIrq

  // One raw result, its corrected copy, the events it sets and the line
  task automatic res(input logic [15:0] d, input logic [3:0] e,
                     input logic ei);
    @(posedge core_clk);
    resultValid <= 1'b1;
    resultData  <= d;
    @(posedge core_clk);
    resultValid <= 1'b0;
    @(posedge core_clk);
    chk("corrValid", 32'h1, {31'h0, corrValid});
    chk("corrData", {16'h0, d - 16'h0300}, {16'h0, corrData});
    rd(OFS_STATUS, {28'h0, e}, 32'hf);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    wr(OFS_STATUS, 32'hf);
  endtask : res

  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(OFS_CTRL, 32'h5005, '1);
    chk("scanHaltOut", 32'h1, {31'h0, scanHaltOut});
    trig();
    wr(OFS_CTRL, 32'h6000);
    chk("starts", 0, nStart);
    wr(OFS_CTRL, 32'hffff);
    rd(OFS_CTRL, 32'h5f07, '1);
    rd(8'h40, 32'h0, '1);
    wr(8'h40, 32'hffff);
    wr(OFS_CTRL, 32'h0000);
    trig();
    chk("starts", 0, nStart);
    wr(OFS_CTRL, 32'h2000);
    wr(OFS_CTRL, 32'h2000);
    waitIdle();
    chk("starts", 1, nStart);
    rd(OFS_STATUS, 32'h0, 32'hf);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, 32'h1000 + m);
      trig();
      trig();
      waitIdle();
      trig();
      chk("starts", 2 + m, nStart);
      rd(OFS_STATUS, 32'h0, 32'h200);
    end
    wr(OFS_CTRL, 32'h1000);
    trig();
    wr(OFS_CTRL, 32'h1000);
    chk("scanBusy", 32'h1, {31'h0, scanBusy});
    waitIdle();
    trig();
    waitIdle();
    chk("starts", 5, nStart);
    wr(OFS_MASK, 32'h1);
    for (int m = 2; m < 4; m++) begin
      wr(OFS_CTRL, 32'h0800 + m);
      wr(OFS_CTRL, 32'h2800 + m);
      waitIrq(1'b1);
      wr(OFS_STATUS, 32'h1);
      waitIrq(1'b0);
      waitIrq(1'b1);
      wr(OFS_CTRL, 32'h4800 + m);
      waitIdle();
      wr(OFS_STATUS, 32'h1);
      repeat (40) @(posedge core_clk);
      chk("irq", 32'h0, {31'h0, irq});
      chk("scanHaltOut", 32'h1, {31'h0, scanHaltOut});
    end
    wr(OFS_LOWLIM, 32'h0100);
    wr(OFS_HIGLIM, 32'h0800);
    wr(OFS_OFFSET, 32'h0300);
    wr(OFS_MASK, 32'hf);
    wr(OFS_CTRL, 32'h0700);
    wr(OFS_STATUS, 32'hf);
    for (int i = 0; i < 9; i++) begin
      wr(OFS_ZCCFG, {30'h0, zcTab[i]});
      res(dTab[i], eTab[i], eTab[i] != 4'h0);
    end
    wr(OFS_MASK, 32'h0);
    res(16'h0050, 4'h6, 1'b0);
    wr(OFS_CTRL, 32'h0000);
    res(16'h0050, 4'h0, 1'b0);
    res(16'h0900, 4'h0, 1'b0);
    res(16'h8000, 4'h0, 1'b0);
    summarize();
  end
endmodule : asc_scan_ctrl_test
